// *** hdl/ufc_pkg.sv ***
// ufc_pkg: shared constants for the uart fifo control block
package ufc_pkg;

  // register byte addresses
  localparam logic [31:0] ADDR_DATA   = 32'h4000_8000; // tx write, rx read
  localparam logic [31:0] ADDR_FCR    = 32'h4000_8008; // fcr write, iir read
  localparam logic [31:0] ADDR_IRQ_ST = 32'h4000_8040; // sticky status
  localparam logic [31:0] ADDR_IRQ_MK = 32'h4000_8044; // interrupt mask
  localparam logic [31:0] ADDR_LEVEL  = 32'h4000_8048; // fill levels

  // fifo_control_reg field positions
  localparam int FCR_EN      = 0;
  localparam int FCR_RX_RST  = 1;
  localparam int FCR_TX_RST  = 2;
  localparam int FCR_TRIG_LO = 6;
  localparam int FCR_TRIG_HI = 7;

  // reset values
  localparam logic       FEN_RST  = 1'b0;
  localparam logic [1:0] TRIG_RST = 2'h0;
  localparam logic [1:0] MASK_RST = 2'h0;

  // receive trigger thresholds in characters
  localparam logic [4:0] TRIG_LVL0 = 5'h01;
  localparam logic [4:0] TRIG_LVL1 = 5'h04;
  localparam logic [4:0] TRIG_LVL2 = 5'h08;
  localparam logic [4:0] TRIG_LVL3 = 5'h0e;

  // irq_ident_reg codes for bits 3:1
  localparam logic [2:0] IID_NONE = 3'h0;
  localparam logic [2:0] IID_RDA  = 3'h2;
  localparam logic [2:0] IID_TX_HOLDING_EMPTY = 3'h1;

  // sticky status bit positions
  localparam int IST_RDA  = 0;
  localparam int IST_TX_HOLDING_EMPTY = 1;

  // fifo geometry
  localparam int FIFO_WIDTH = 8;
  localparam int FIFO_DEPTH = 16;

  // timing: character time less the stop bit
  localparam int CLK_PERIOD_NS = 20;
  localparam int BIT_TIME_NS   = 8680;
  localparam int CHAR_BITS     = 9;
  localparam int TX_HOLDING_EMPTY_DLY_CYC  =
    (CHAR_BITS * BIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

endpackage

// *** hdl/ufc_fifo_if.sv ***
// ufc_fifo_if: connection between the controller and one character fifo
`timescale 1ns/1ps
interface ufc_fifo_if #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
);
  logic                         push;
  logic                         pop;
  logic                         flush;
  logic [WIDTH-1:0]             wdata;
  logic [WIDTH-1:0]             rdata;
  logic [$clog2(DEPTH+1)-1:0]   count;
  logic                         full;
  logic                         empty;

  modport ctrl  (output push, pop, flush, wdata,
                 input  rdata, count, full, empty);
  modport store (input  push, pop, flush, wdata,
                 output rdata, count, full, empty);
endinterface

// *** hdl/ufc_fifo.sv ***
// ufc_fifo: synchronous character fifo with flush
`timescale 1ns/1ps
module ufc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // clock and reset
  input wire logic   clock,
  input wire logic   nrst,
  // fifo side
  ufc_fifo_if.store  f
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH+1);

  generate
    if (DEPTH < 2 || (1 << AW) != DEPTH)
    begin : g_chk
      $error("fifo depth must be a power of two");
    end
  endgenerate

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wptr_r;
  logic [AW-1:0]    rptr_r;
  logic [CW-1:0]    cnt_r;
  logic [CW-1:0]    cnt_nxt;
  wire              do_push = f.push && !f.full;
  wire              do_pop  = f.pop && !f.empty;

  // flat outputs; head is read combinationally
  assign f.full  = (cnt_r == CW'(DEPTH));
  assign f.empty = (cnt_r == '0);
  assign f.count = cnt_r;
  assign f.rdata = mem[rptr_r];

  // count follows push and pop together
  always_comb
  begin
    cnt_nxt = cnt_r;
    if (do_push && !do_pop)
      cnt_nxt = cnt_r + 1'b1;
    else if (do_pop && !do_push)
      cnt_nxt = cnt_r - 1'b1;
  end

  // flush discards contents and resets the pointers
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      wptr_r <= '0;
      rptr_r <= '0;
      cnt_r  <= '0;
    end
    else if (f.flush)
    begin
      wptr_r <= '0;
      rptr_r <= '0;
      cnt_r  <= '0;
    end
    else
    begin
      if (do_push)
        wptr_r <= wptr_r + 1'b1;
      if (do_pop)
        rptr_r <= rptr_r + 1'b1;
      cnt_r <= cnt_nxt;
    end
  end

  // storage carries no reset; stale words are never read as valid
  always_ff @(posedge clock)
  begin
    if (do_push && !f.flush)
      mem[wptr_r] <= f.wdata;
  end
endmodule

// *** hdl/ufc_top.sv ***
// ufc_top: uart fifo control and tx holding empty interrupt
//
// Overview of operation
// - holding-empty is third priority, code 001
// - delay holding-empty a character less stop bit
// - no delay if two characters were held
// - clear on holding write or ident read showing code 001
// - enable bit gates data-available and bits 7:1; fifos fill regardless
// - enable bit change empties both fifos
// - bit 1 self-clearing receive fifo reset
// - bit 2 self-clearing transmit fifo reset
// - bits 7:6 pick trigger 1,4,8,14
// - control write-only, bits 5:4 zero
// - data-available follows fill against trigger
`timescale 1ns/1ps
module ufc_top
  import ufc_pkg::*;
#(
  parameter int DEPTH   = FIFO_DEPTH,
  parameter int DLY_CYC = TX_HOLDING_EMPTY_DLY_CYC
) (
  // clock and reset
  input  wire logic        clock,
  input  wire logic        nrst,
  // register port
  input  wire logic [31:0] addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr_en,
  input  wire logic        rd_en,
  output logic      [31:0] rdata,
  // interrupt
  output logic             irq,
  // receiver side
  input  wire logic        rx_valid,
  input  wire logic [7:0]  rx_char,
  // transmitter side
  input  wire logic        tx_req,
  output logic      [7:0]  tx_data,
  output logic             tx_valid,
  output logic             tx_empty
);
  localparam int CW = $clog2(DEPTH+1);

  // the highest trigger must fit without overflow; the level fields are
  // five bits wide and the delay counter sixteen, which bounds the rest
  generate
    if (DEPTH < 16 || DEPTH > 31 || DLY_CYC < 1 || DLY_CYC > 65535)
    begin : g_chk
      $error("depth or start-up delay out of range");
    end
  endgenerate

  // address compare shared by all strobe decodes
  function automatic logic hit(input logic [31:0] a,
                               input logic [31:0] off);
    hit = (a == off);
  endfunction

  // threshold for a trigger selection
  function automatic logic [4:0] trig_lvl(input logic [1:0] sel);
    case (sel)
      2'h0:    trig_lvl = TRIG_LVL0;
      2'h1:    trig_lvl = TRIG_LVL1;
      2'h2:    trig_lvl = TRIG_LVL2;
      default: trig_lvl = TRIG_LVL3;
    endcase
  endfunction

  ufc_fifo_if #(.WIDTH(FIFO_WIDTH), .DEPTH(DEPTH)) rxf ();
  ufc_fifo_if #(.WIDTH(FIFO_WIDTH), .DEPTH(DEPTH)) txf ();

  // receive and transmit character stores
  ufc_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(DEPTH)) u_rx_fifo
  (
    .clock (clock),
    .nrst  (nrst),
    .f     (rxf.store)
  );

  ufc_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(DEPTH)) u_tx_fifo
  (
    .clock (clock),
    .nrst  (nrst),
    .f     (txf.store)
  );

  // state registers
  logic        fen_r;
  logic [1:0]  trig_r;
  logic        tx_holding_empty_r;
  logic        held2_r;
  logic        empty_d_r;
  logic        dly_run_r;
  logic [15:0] dly_cnt_r;
  logic        rda_d_r;
  logic [1:0]  ist_r;
  logic [1:0]  ist_nxt;
  logic [1:0]  mask_r;
  logic [31:0] rdata_r;
  logic        irq_r;
  logic [7:0]  tx_data_r;
  logic        tx_valid_r;

  // strobe decode
  wire wr_data = wr_en && hit(addr, ADDR_DATA);
  wire wr_fcr  = wr_en && hit(addr, ADDR_FCR);
  wire wr_ist  = wr_en && hit(addr, ADDR_IRQ_ST);
  wire wr_mask = wr_en && hit(addr, ADDR_IRQ_MK);
  wire rd_data = rd_en && hit(addr, ADDR_DATA);
  wire rd_iir  = rd_en && hit(addr, ADDR_FCR);
  // the ident read shares the control address; the bus never raises
  // both strobes at once, so the two decodes cannot collide

  // any change of the enable bit empties both fifos
  wire fen_new = wdata[FCR_EN];
  wire fen_chg = wr_fcr && (fen_new != fen_r);
  // reset bits act only in a write that also holds the enable bit;
  // they are never stored; a read at the control address returns the ident
  wire rx_rst  = wr_fcr && fen_new && wdata[FCR_RX_RST];
  wire tx_rst  = wr_fcr && fen_new && wdata[FCR_TX_RST];

  // fifo control; flush inside the fifo wins over push and pop
  assign rxf.flush = fen_chg || rx_rst;
  assign txf.flush = fen_chg || tx_rst;
  assign rxf.push  = rx_valid;
  assign rxf.wdata = rx_char;
  assign rxf.pop   = rd_data;
  assign txf.push  = wr_data;
  assign txf.wdata = wdata[7:0];
  assign txf.pop   = tx_req;

  // data available: fill level at or above the selected threshold
  wire [4:0] lvl = trig_lvl(trig_r);
  wire       rx_data_avail = fen_r && (rxf.count >= CW'(lvl));
  wire       rda_rise = rx_data_avail && !rda_d_r;

  // holding-empty start-up: an empty edge either fires at once or
  // waits one character less the stop bit so software can refill
  wire tx_holding_empty_evt   = txf.empty && !empty_d_r;
  wire dly_done   = dly_run_r && txf.empty && (dly_cnt_r == '0);
  wire tx_holding_empty_set   = (tx_holding_empty_evt && held2_r) || dly_done;
  wire tx_holding_empty_top   = tx_holding_empty_r && !rx_data_avail;
  wire tx_holding_empty_clr   = wr_data || (rd_iir && tx_holding_empty_top);

  // identification: data available outranks holding-empty
  wire [2:0] iid  = rx_data_avail ? IID_RDA : (tx_holding_empty_r ? IID_TX_HOLDING_EMPTY : IID_NONE);
  wire       pend = rx_data_avail || tx_holding_empty_r;
  // reserved bits 5:4 read as zero here
  wire [31:0] iir_val = {24'h0, fen_r, fen_r, 2'h0, iid, !pend};
  // fill levels as five-bit fields; the depth check keeps them exact
  wire [4:0]  rx_lvl  = 5'(rxf.count);
  wire [4:0]  tx_lvl  = 5'(txf.count);
  wire [31:0] lvl_val = {19'h0, rx_lvl, 3'h0, tx_lvl};

  // read selection; unmapped addresses answer zero
  wire [31:0] rbr_val = rxf.empty ? 32'h0 : {24'h0, rxf.rdata};
  wire [31:0] rd_mux  =
    hit(addr, ADDR_DATA)   ? rbr_val :
    hit(addr, ADDR_FCR)    ? iir_val : // control itself is write-only
    hit(addr, ADDR_IRQ_ST) ? {30'h0, ist_r} :
    hit(addr, ADDR_IRQ_MK) ? {30'h0, mask_r} :
    hit(addr, ADDR_LEVEL)  ? lvl_val : 32'h0;

  // sticky status: a new event wins over a same-cycle clear
  // a clear only touches the bits written as one
  always_comb
  begin
    ist_nxt = ist_r;
    if (wr_ist)
      ist_nxt = ist_r & ~wdata[1:0];
    ist_nxt[IST_RDA]  = ist_nxt[IST_RDA] | rda_rise;
    ist_nxt[IST_TX_HOLDING_EMPTY] = ist_nxt[IST_TX_HOLDING_EMPTY] | tx_holding_empty_set;
  end

  // fifo control register; bits 7:1 only land with the enable set
  // clearing the enable is unsupported, yet still honoured: both fifos
  // empty and the trigger keeps its last value
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      fen_r  <= FEN_RST;
      trig_r <= TRIG_RST;
    end
    else if (wr_fcr)
    begin
      fen_r <= fen_new;
      if (fen_new)
        trig_r <= wdata[FCR_TRIG_HI:FCR_TRIG_LO];
    end
  end

  // tracks whether two characters were held since the last empty
  // the registered fill is used, so a pair that stands one cycle counts
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      held2_r   <= 1'b0;
      empty_d_r <= 1'b0;
    end
    else
    begin
      empty_d_r <= txf.empty;
      if (tx_holding_empty_evt)
        held2_r <= 1'b0;
      else if (txf.count >= CW'(2))
        held2_r <= 1'b1;
    end
  end

  // start-up delay; a refill during the wait cancels it
  // loaded with DLY_CYC-1, so the flag sets DLY_CYC edges after the load
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      dly_run_r <= 1'b0;
      dly_cnt_r <= '0;
    end
    else if (tx_holding_empty_evt && !held2_r)
    begin
      dly_run_r <= 1'b1;
      dly_cnt_r <= 16'(DLY_CYC - 1);
    end
    else if (dly_run_r)
    begin
      if (!txf.empty || dly_cnt_r == '0)
        dly_run_r <= 1'b0;
      else
        dly_cnt_r <= dly_cnt_r - 1'b1;
    end
  end

  // holding-empty pending flag; set wins over clear
  // a holding write in the very cycle of a set is lost to the set, so
  // software may see one spare interrupt; missing one would be worse
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      tx_holding_empty_r <= 1'b0;
    else if (tx_holding_empty_set)
      tx_holding_empty_r <= 1'b1;
    else if (tx_holding_empty_clr)
      tx_holding_empty_r <= 1'b0;
  end

  // interrupt status, mask and output
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      ist_r   <= '0;
      mask_r  <= MASK_RST;
      rda_d_r <= 1'b0;
      irq_r   <= 1'b0;
    end
    else
    begin
      ist_r   <= ist_nxt;
      rda_d_r <= rx_data_avail;
      irq_r   <= |(ist_r & mask_r);
      if (wr_mask)
        mask_r <= wdata[1:0];
    end
  end

  // register read data stands only in the cycle after the strobe
  // zero outside a read, so the data can be or-ed with other slaves
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      rdata_r <= '0;
    else
      rdata_r <= rd_en ? rd_mux : 32'h0;
  end

  // character hand-off to the transmitter
  // tx_data keeps the last character until the next pop
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      tx_data_r  <= '0;
      tx_valid_r <= 1'b0;
    end
    else
    begin
      tx_valid_r <= tx_req && !txf.empty;
      if (tx_req && !txf.empty)
        tx_data_r <= txf.rdata;
    end
  end

  // every output comes straight from a register
  assign rdata    = rdata_r;
  assign irq      = irq_r;
  assign tx_data  = tx_data_r;
  assign tx_valid = tx_valid_r;
  assign tx_empty = empty_d_r;
endmodule

// *** verification/ufc_top_asserts.sv ***
// ufc_top_asserts: port-level checks for the fifo control block
`timescale 1ns/1ps
module ufc_top_asserts
  import ufc_pkg::*;
#(
  parameter int DEPTH   = FIFO_DEPTH,
  parameter int DLY_CYC = TX_HOLDING_EMPTY_DLY_CYC
) (
  // clock and reset
  input wire logic        clock,
  input wire logic        nrst,
  // register port
  input wire logic [31:0] addr,
  input wire logic [31:0] wdata,
  input wire logic        wr_en,
  input wire logic        rd_en,
  input wire logic [31:0] rdata,
  // interrupt and links
  input wire logic        irq,
  input wire logic        rx_valid,
  input wire logic [7:0]  rx_char,
  input wire logic        tx_req,
  input wire logic [7:0]  tx_data,
  input wire logic        tx_valid,
  input wire logic        tx_empty
);
  // address decodes shared by the properties
  wire logic rd_fcr = rd_en && addr == ADDR_FCR;
  wire logic mapped = addr inside {ADDR_DATA, ADDR_FCR, ADDR_IRQ_ST,
                                   ADDR_IRQ_MK, ADDR_LEVEL};

  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);

  rdata_idle_a: assert property (!$past(rd_en) |-> rdata == 32'h0)
    else $error("read data not zero outside a read");
  iir_fmt_a: assert property (rd_fcr |=> rdata[31:8] == 24'h0
    && rdata[5:4] == 2'h0 && rdata[7] == rdata[6])
    else $error("ident read has bad reserved or enable bits");
  iir_pend_a: assert property (rd_fcr |=>
    rdata[0] == (rdata[3:1] == IID_NONE))
    else $error("pending flag disagrees with ident code");
  unmapped_rd_a: assert property (rd_en && !mapped |=>
    rdata == 32'h0)
    else $error("unmapped read returned data");
  level_rng_a: assert property (rd_en && addr == ADDR_LEVEL |=>
    rdata[12:8] <= DEPTH && rdata[4:0] <= DEPTH
    && rdata[31:13] == 19'h0 && rdata[7:5] == 3'h0)
    else $error("fill level out of range");
  tx_flush_a: assert property (wr_en && addr == ADDR_FCR
    && wdata[0] && wdata[2] |-> ##2 tx_empty)
    else $error("transmit flush left data behind");
  tx_cause_a: assert property (tx_valid |-> $past(tx_req))
    else $error("transmit output without a request");
  mask_off_a: assert property (wr_en && addr == ADDR_IRQ_MK
    && wdata[1:0] == 2'h0 |-> ##2 !irq)
    else $error("interrupt high with all sources masked");

  tx_holding_empty_seen_c: cover property (rd_fcr ##1 rdata[3:1] == IID_TX_HOLDING_EMPTY);
  rda_seen_c: cover property (rd_fcr ##1 rdata[3:1] == IID_RDA);
  irq_seen_c: cover property (irq);
endmodule

bind ufc_top ufc_top_asserts #(.DEPTH(DEPTH), .DLY_CYC(DLY_CYC))
  ufc_top_asserts_inst (.clock(clock), .nrst(nrst), .addr(addr),
  .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .irq(irq),
  .rx_valid(rx_valid), .rx_char(rx_char), .tx_req(tx_req),
  .tx_data(tx_data), .tx_valid(tx_valid), .tx_empty(tx_empty));

// *** verification/ufc_serial_model.sv ***
// ufc_serial_model: far-side receiver and transmitter stand-in
`timescale 1ns/1ps
module ufc_serial_model (
  // clock and reset
  input  wire logic       clock,
  input  wire logic       nrst,
  // commands from the bench
  input  wire logic       send,
  input  wire logic [7:0] send_char,
  input  wire logic       pull,
  // link toward the block
  output logic            rx_valid,
  output logic [7:0]      rx_char,
  output logic            tx_req
);
  // idle data inverts so a stale character can never pass for a new one
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      rx_valid <= 1'b0;
      rx_char  <= 8'h00;
      tx_req   <= 1'b0;
    end
    else
    begin
      rx_valid <= send;
      rx_char  <= send ? send_char : ~rx_char;
      tx_req   <= pull;
    end
  end
endmodule

// *** verification/tb_top.sv ***
// tb_top: self-checking bench for the uart fifo control block
`timescale 1ns/1ps
module tb_top
  import ufc_pkg::*;
;
  `define CHK(g, e) begin checks++; if ((g) !== (e)) begin error_cnt++; \
    $display("wrong value at %0t: got %h exp %h", $time, g, e); end end
  localparam int DLY = 8;
  logic        clock, nrst, wr_en, rd_en, send, pull;
  logic [31:0] addr, wdata, rdata, rv;
  logic        irq, rx_valid, tx_req, tx_valid, tx_empty;
  logic [7:0]  rx_char, tx_data, send_char, c;
  int          error_cnt, checks, cyc;
  logic [7:0]  q[$];

  ufc_top #(.DEPTH(16), .DLY_CYC(DLY)) ufc_top_inst (.clock(clock),
    .nrst(nrst), .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en),
    .rdata(rdata), .irq(irq), .rx_valid(rx_valid), .rx_char(rx_char),
    .tx_req(tx_req), .tx_data(tx_data), .tx_valid(tx_valid),
    .tx_empty(tx_empty));
  ufc_serial_model ufc_serial_model_inst (.clock(clock), .nrst(nrst),
    .send(send), .send_char(send_char), .pull(pull), .rx_valid(rx_valid),
    .rx_char(rx_char), .tx_req(tx_req));

  // 50 mhz clock
  initial
  begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  // hang guard: the whole run needs well under a thousand cycles
  always @(posedge clock)
  begin
    cyc++;
    if (cyc > 3000)
    begin
      error_cnt++;
      report_and_stop();
    end
  end

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge clock);
    wr_en <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge clock);
    wr_en <= 1'b0;
  endtask

  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [31:0] a);
    @(posedge clock);
    rd_en <= 1'b1;
    addr  <= a;
    @(posedge clock);
    rd_en <= 1'b0;
    #1 rv = rdata;
  endtask

  task automatic push(input int n);
    repeat (n)
    begin
      @(posedge clock);
      c = 8'($urandom);
      q.push_back(c);
      send      <= 1'b1;
      send_char <= c;
    end
    @(posedge clock);
    send <= 1'b0;
    repeat (2) @(posedge clock);
  endtask

  task automatic pop_chk(input logic [7:0] e);
    @(posedge clock);
    pull <= 1'b1;
    @(posedge clock);
    pull <= 1'b0;
    repeat (5)
    begin
      @(posedge clock);
      #1 if (tx_valid === 1'b1) break;
    end
    `CHK(tx_valid, 1'b1)
    `CHK(tx_data, e)
  endtask

  function automatic logic [31:0] iir_e(input logic f, input logic [2:0] id);
    return {24'h0, f, f, 2'h0, id, id == IID_NONE};
  endfunction

  function automatic int trig(input int t);
    return t == 0 ? 1 : t == 1 ? 4 : t == 2 ? 8 : 14;
  endfunction

  task automatic report_and_stop();
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // main sequence
  initial
  begin
    {nrst, wr_en, rd_en, send, pull} = 5'h0;
    {addr, wdata, send_char} = 72'h0;
    {error_cnt, checks, cyc} = 96'h0;
    void'($urandom(35));
    repeat (10) @(posedge clock);
    nrst <= 1'b1;
    // the empty fifo at reset raises holding-empty only after the delay
    rd(ADDR_FCR);
    `CHK(rv, iir_e(1'b0, IID_NONE))
    repeat (DLY + 4) @(posedge clock);
    rd(ADDR_FCR);
    `CHK(rv, iir_e(1'b0, IID_TX_HOLDING_EMPTY))
    rd(ADDR_FCR);
    `CHK(rv, iir_e(1'b0, IID_NONE))
    wr(ADDR_FCR, 32'h1);
    rd(ADDR_FCR);
    `CHK(rv, iir_e(1'b1, IID_NONE))
    // every trigger code, each after a receive flush
    for (int t = 0; t < 4; t++)
    begin
      wr(ADDR_FCR, 32'(t * 64 + 3));
      q.delete();
      push(trig(t) - 1);
      rd(ADDR_FCR);
      `CHK(rv, iir_e(1'b1, IID_NONE))
      push(1);
      rd(ADDR_FCR);
      `CHK(rv, iir_e(1'b1, IID_RDA))
      rd(ADDR_DATA);
      `CHK(rv[7:0], q.pop_front())
      rd(ADDR_FCR);
      `CHK(rv, iir_e(1'b1, IID_NONE))
    end
    // overfill the receiver: the level stops at sixteen
    push(4);
    rd(ADDR_LEVEL);
    `CHK(rv, 32'h0000_1000)
    // two held characters, so emptying raises holding-empty at once
    wr(ADDR_FCR, 32'hc3);
    q.delete();
    for (int i = 0; i < 2; i++)
    begin
      q.push_back(8'($urandom));
      wr(ADDR_DATA, {24'h0, q[i]});
    end
    pop_chk(q[0]);
    `CHK(tx_empty, 1'b0)
    pop_chk(q[1]);
    rd(ADDR_FCR);
    `CHK(rv, iir_e(1'b1, IID_TX_HOLDING_EMPTY))
    `CHK(tx_empty, 1'b1)
    // flushing a single held character takes the delayed path
    wr(ADDR_DATA, 32'h5a);
    wr(ADDR_IRQ_ST, 32'h3);
    wr(ADDR_FCR, 32'hc5);
    rd(ADDR_IRQ_ST);
    `CHK(rv, 32'h0)
    repeat (DLY + 2) @(posedge clock);
    rd(ADDR_IRQ_ST);
    `CHK(rv, 32'h2)
    wr(ADDR_IRQ_MK, 32'h2);
    repeat (2) @(posedge clock);
    `CHK(irq, 1'b1)
    wr(ADDR_IRQ_ST, 32'h2);
    repeat (2) @(posedge clock);
    `CHK(irq, 1'b0)
    wr(ADDR_IRQ_MK, 32'h0);
    wr(ADDR_DATA, 32'h33);
    rd(ADDR_FCR);
    `CHK(rv, iir_e(1'b1, IID_NONE))
    // dropping the enable empties both fifos and ignores the upper bits
    push(2);
    wr(ADDR_FCR, 32'hc0);
    rd(ADDR_LEVEL);
    `CHK(rv, 32'h0)
    rd(ADDR_FCR);
    `CHK(rv, iir_e(1'b0, IID_NONE))
    // with the enable clear, a receive reset request must be ignored
    push(1);
    wr(ADDR_FCR, 32'h6);
    rd(ADDR_LEVEL);
    `CHK(rv, 32'h0000_0100)
    rd(32'h4000_8004);
    `CHK(rv, 32'h0)
    report_and_stop();
  end
endmodule
